// File: hdl/aop_top.sv
// angle output: duty cycle pwm and triggered nibble frames, apb registers
//
// Summary of operation
// RQ1: pwm duty rises with angle, zero smallest
// RQ2: frequency, data range, diag levels all configurable
// RQ3: full 12-bit angle spans configured data range
// RQ4: fault outputs low diagnostic duty cycle
// RQ5: self-test fail or reset outputs high diagnostic
// RQ6: angle duty never leaves data range
// RQ7: configurer keeps diagnostic levels outside data range
// RQ8: period starts with programmable rising or falling
// RQ9: frequency within five percent; receiver measures period
// RQ10: nibble frames sent only after trigger pulse
// RQ11: nibble value is falling-edge interval 12-27
// RQ12: sync, status, data, counter, crc, end
// RQ13: rolling counter nibble only when enabled
// RQ14: unit time 1.5 to 3.0 us selectable
// RQ15: crc covers status and data nibbles
// RQ16: error bit set while present, once minimum
// RQ17: status bits 0,1 message or address
// RQ18: status bit 2 warning, bit 3 error
// RQ19: answer only triggers matching own address
// RQ20: trigger length constant 90 or low+12
// RQ21: integrator copies strap address into bus address
// RQ22: programming address read from two strap pins
// RQ23: trigger low time windows encode the address
// RQ24: rolling counter increments per frame, wraps
// RQ25: nibble mode releases line, open drain
// RQ26: high time is min plus angle*span/4096
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

module aop_top
   import aop_pkg::*;
#(
   parameter int unsigned PWM_PER_DEF = aop_pkg::PWM_PER_RST
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [11:0] angle_code,
   input  wire logic        fault_warn,
   input  wire logic        selftest_fail,
   input  wire logic        ssm_data,
   input  wire logic        ssm_start,
   input  wire logic        address_strap_a,
   input  wire logic        address_strap_b,
   input  wire logic        line_in,
   output logic             line_out,
   output logic             line_oe
);
   import aop_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRIG_LOW,
      ST_TRIG_WAIT,
      ST_SEND
   } aop_state_e;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [PER_W-1:0]  period;
      logic [DC_W-1:0]   data_min;
      logic [DC_W-1:0]   data_span;
      logic [DC_W-1:0]   diag_lo;
      logic [DC_W-1:0]   diag_hi;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic [PER_W-1:0]  pwm_cnt;
      logic [PER_W-1:0]  pwm_high;
      logic              line_out;
      logic              line_oe;
      logic              line_prev;
      logic [1:0]        strap_addr;
      logic              strap_done;
      logic              reset_ind;
      logic              warn_hold;
      logic              err_hold;
      logic [3:0]        roll_cnt;
      logic [3:0]        last_status;
      aop_state_e        state;
      logic [8:0]        cyc_cnt;
      logic [7:0]        half_cnt;
      logic [7:0]        trig_target;
      logic [2:0]        slot;
      logic [23:0]       frame;
   } aop_regs_s;

   aop_regs_s s_ff;
   aop_regs_s nxt_s;

   // trigger low time (half units) against one address window
   function automatic logic addr_match(input logic [1:0] addr,
                                       input logic [7:0] h);
      logic m;
      case (addr)
         2'd0:    m = (h >= WIN0_LO) && (h <= WIN0_HI);
         2'd1:    m = (h >= WIN1_LO) && (h <= WIN1_HI);
         2'd2:    m = (h >= WIN2_LO) && (h <= WIN2_HI);
         default: m = (h >= WIN3_LO) && (h <= WIN3_HI);
      endcase
      return m;
   endfunction

   // high time in clock cycles for a duty in 1/4096 of the period
   function automatic logic [PER_W-1:0] duty_cycles(
      input logic [PER_W-1:0] per,
      input logic [DC_W-1:0]  dc);
      logic [PER_W+DC_W-1:0] prod;
      prod = per * dc;
      return prod[PER_W+11:12];
   endfunction

   logic [3:0]        slot_nib;
   logic [7:0]        slot_len;
   logic [7:0]        nlow_ut;
   logic [8:0]        half_ut;
   logic              half_tick;
   logic              line_fall;
   logic              line_rise;
   logic [DC_W-1:0]   data_dc;
   logic [DC_W-1:0]   sel_dc;
   logic [DC_W+11:0]  ang_prod;
   logic [3:0]        status_nib;
   logic [3:0]        crc;
   logic [1:0]        bus_addr;

   always_comb
   begin
      nxt_s = s_ff;
      bus_addr = s_ff.ctrl[CTRL_ADDR_LSB +: 2];
      nlow_ut = s_ff.ctrl[CTRL_NLOW5] ? NLOW5_UT : NLOW3_UT;
      // unit time grows in 0.5 us steps from 1.5 us
      half_ut = HALF_BASE_CYC
              + 9'(s_ff.ctrl[CTRL_UT_LSB +: 2] * HALF_STEP_CYC); // see RQ14
      half_tick = (s_ff.cyc_cnt + 9'd1) >= half_ut;
      line_fall = s_ff.line_prev && !line_in;
      line_rise = !s_ff.line_prev && line_in;

      // apb: ready in the access phase, so no wait states
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;
      if (psel && !penable)
      begin
         nxt_s.pready = 1'b1;
         nxt_s.prdata = 32'h0000_0000;
         case (paddr)
            OFS_CTRL:    nxt_s.prdata = 32'(s_ff.ctrl);
            OFS_PERIOD:  nxt_s.prdata = 32'(s_ff.period);
            OFS_DATA_DC: nxt_s.prdata = {3'b000, s_ff.data_span,
                                         3'b000, s_ff.data_min};
            OFS_DIAG_DC: nxt_s.prdata = {3'b000, s_ff.diag_hi,
                                         3'b000, s_ff.diag_lo};
            OFS_STATUS:  nxt_s.prdata = {20'h0_0000, s_ff.last_status,
                                         s_ff.roll_cnt, s_ff.reset_ind,
                                         s_ff.state != ST_IDLE,
                                         s_ff.strap_addr};
            default:     nxt_s.pslverr = 1'b1;
         endcase
      end
      // configuration choices are trusted to keep diag apart from data
      if (psel && penable && s_ff.pready && pwrite)
      begin
         case (paddr)
            OFS_CTRL:   nxt_s.ctrl = pwdata[CTRL_W-1:0];
            OFS_PERIOD: nxt_s.period = pwdata[PER_W-1:0]; // see RQ2
            OFS_DATA_DC:
            begin
               nxt_s.data_min  = pwdata[DC_W-1:0]; // see RQ3
               nxt_s.data_span = pwdata[DC_HI_LSB +: DC_W];
            end
            OFS_DIAG_DC:
            begin
               nxt_s.diag_lo = pwdata[DC_W-1:0]; // see RQ7
               nxt_s.diag_hi = pwdata[DC_HI_LSB +: DC_W];
            end
            default:
            begin
            end
         endcase
      end

      // straps sampled once, the first clock after reset release
      if (!s_ff.strap_done)
      begin
         nxt_s.strap_addr = {address_strap_b, address_strap_a}; // see RQ22
         nxt_s.strap_done = 1'b1;
      end

      // sticky copies keep a transient error alive until it is sent
      status_nib = {s_ff.err_hold | selftest_fail | s_ff.reset_ind,
                    s_ff.warn_hold | fault_warn,
                    s_ff.ctrl[CTRL_SSM_EN] ? {ssm_start, ssm_data}
                                           : bus_addr}; // see RQ17
      crc = CRC_SEED;
      crc = aop_crc_nib(crc, status_nib);
      for (int k = 2; k >= 0; k--)
         crc = aop_crc_nib(crc, angle_code[k*4 +: 4]);
      crc = aop_crc_nib(crc, 4'h0); // see RQ15

      // pwm duty selection, diagnostics override data
      ang_prod = angle_code * s_ff.data_span;
      data_dc = s_ff.data_min + ang_prod[DC_W+11:12]; // see RQ26
      if (selftest_fail || s_ff.reset_ind)
         sel_dc = s_ff.diag_hi; // see RQ5
      else if (fault_warn || s_ff.warn_hold)
         sel_dc = s_ff.diag_lo; // see RQ4
      else
         sel_dc = data_dc; // see RQ1

      case (s_ff.slot)
         3'd1:    slot_nib = s_ff.frame[23:20];
         3'd2:    slot_nib = s_ff.frame[19:16];
         3'd3:    slot_nib = s_ff.frame[15:12];
         3'd4:    slot_nib = s_ff.frame[11:8];
         3'd5:    slot_nib = s_ff.frame[7:4];
         default: slot_nib = s_ff.frame[3:0];
      endcase
      case (s_ff.slot)
         3'd0:    slot_len = SYNC_UT;
         3'd7:    slot_len = END_UT;
         default: slot_len = NIB_BASE_UT + 8'(slot_nib); // see RQ11
      endcase

      nxt_s.line_prev = line_in;
      nxt_s.warn_hold = s_ff.warn_hold | fault_warn;
      nxt_s.err_hold  = s_ff.err_hold | selftest_fail;
      nxt_s.line_out  = 1'b0;

      if (!s_ff.ctrl[CTRL_MODE])
      begin
         // pwm: push-pull, new high time taken once per period
         nxt_s.state   = ST_IDLE;
         nxt_s.line_oe = 1'b1;
         if (s_ff.pwm_cnt + 20'd1 >= s_ff.period)
         begin
            nxt_s.pwm_cnt  = '0;
            nxt_s.pwm_high = duty_cycles(s_ff.period, sel_dc); // see RQ6
            // fault flags consumed by the period that showed them
            nxt_s.reset_ind = 1'b0;
            nxt_s.warn_hold = fault_warn;
            nxt_s.err_hold  = selftest_fail;
         end
         else
            nxt_s.pwm_cnt = s_ff.pwm_cnt + 20'd1;
         // falling start: low first, high time at the period's end
         if (s_ff.ctrl[CTRL_FALL])
            nxt_s.line_out = nxt_s.pwm_cnt >= s_ff.period - nxt_s.pwm_high;
         else
            nxt_s.line_out = nxt_s.pwm_cnt < nxt_s.pwm_high; // see RQ8
      end
      else
      begin
         // nibble mode: only ever pull low, otherwise release
         nxt_s.line_oe = 1'b0; // see RQ25
         nxt_s.cyc_cnt = half_tick ? 9'd0 : s_ff.cyc_cnt + 9'd1;
         case (s_ff.state)
            ST_IDLE:
            begin
               if (line_fall) // see RQ10
               begin
                  nxt_s.state    = ST_TRIG_LOW;
                  nxt_s.half_cnt = '0;
                  nxt_s.cyc_cnt  = '0;
               end
            end
            ST_TRIG_LOW:
            begin
               if (half_tick && s_ff.half_cnt != 8'hff)
                  nxt_s.half_cnt = s_ff.half_cnt + 8'd1;
               if (line_rise)
               begin
                  if (addr_match(bus_addr, s_ff.half_cnt)) // see RQ19
                  begin
                     nxt_s.state = ST_TRIG_WAIT;
                     nxt_s.trig_target = s_ff.ctrl[CTRL_VAR_TRIG]
                        ? s_ff.half_cnt + {TRIG_TAIL_UT[6:0], 1'b0}
                        : {TRIG_CONST_UT[6:0], 1'b0}; // see RQ20
                  end
                  else
                     nxt_s.state = ST_IDLE; // see RQ23
               end
            end
            ST_TRIG_WAIT:
            begin
               if (half_tick)
                  nxt_s.half_cnt = s_ff.half_cnt + 8'd1;
               if (s_ff.half_cnt >= s_ff.trig_target)
               begin
                  nxt_s.state    = ST_SEND;
                  nxt_s.slot     = '0;
                  nxt_s.half_cnt = '0;
                  nxt_s.cyc_cnt  = '0;
                  nxt_s.frame    = {status_nib, angle_code,
                                    s_ff.roll_cnt, crc}; // see RQ12
                  nxt_s.last_status = status_nib; // see RQ18
                  nxt_s.reset_ind = 1'b0;
                  // set wins: an event this cycle stays held
                  nxt_s.warn_hold = fault_warn; // see RQ16
                  nxt_s.err_hold  = selftest_fail;
               end
            end
            ST_SEND:
            begin
               nxt_s.line_oe = s_ff.half_cnt < {nlow_ut[6:0], 1'b0};
               if (half_tick)
               begin
                  if (s_ff.half_cnt + 8'd1 >= {slot_len[6:0], 1'b0})
                  begin
                     nxt_s.half_cnt = '0;
                     if (s_ff.slot == 3'd7)
                     begin
                        nxt_s.state    = ST_IDLE;
                        nxt_s.roll_cnt = s_ff.roll_cnt + 4'd1; // see RQ24
                     end
                     else if (s_ff.slot == 3'd4 && !s_ff.ctrl[CTRL_RC_EN])
                        nxt_s.slot = 3'd6; // see RQ13
                     else
                        nxt_s.slot = s_ff.slot + 3'd1;
                  end
                  else
                     nxt_s.half_cnt = s_ff.half_cnt + 8'd1;
               end
            end
            default: nxt_s.state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff             <= '0;
         s_ff.ctrl        <= CTRL_RST;
         s_ff.period      <= PER_W'(PWM_PER_DEF);
         s_ff.data_min    <= DATA_MIN_RST;
         s_ff.data_span   <= DATA_SPAN_RST;
         s_ff.diag_lo     <= DIAG_LO_RST;
         s_ff.diag_hi     <= DIAG_HI_RST;
         s_ff.line_prev   <= 1'b1;
         s_ff.reset_ind   <= 1'b1;
         s_ff.state       <= ST_IDLE;
      end
      else
         s_ff <= nxt_s;
   end

   assign prdata   = s_ff.prdata;
   assign pready   = s_ff.pready;
   assign pslverr  = s_ff.pslverr;
   assign line_out = s_ff.line_out;
   assign line_oe  = s_ff.line_oe;

endmodule

// File: hdl/aop_pkg.sv
// constants and helper functions for the angle output pwm / nibble block
package aop_pkg;

   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CLK_MHZ         = CLK_HZ / 1_000_000;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PERIOD  = 8'h04;
   localparam logic [7:0] OFS_DATA_DC = 8'h08;
   localparam logic [7:0] OFS_DIAG_DC = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;

   // control register fields
   localparam int unsigned CTRL_MODE     = 0;
   localparam int unsigned CTRL_FALL     = 1;
   localparam int unsigned CTRL_RC_EN    = 2;
   localparam int unsigned CTRL_SSM_EN   = 3;
   localparam int unsigned CTRL_VAR_TRIG = 4;
   localparam int unsigned CTRL_UT_LSB   = 5;
   localparam int unsigned CTRL_NLOW5    = 7;
   localparam int unsigned CTRL_ADDR_LSB = 8;
   localparam int unsigned CTRL_W        = 10;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h004;

   // duty registers: low field at bit 0, high field at bit 16
   localparam int unsigned DC_W       = 13;
   localparam int unsigned DC_HI_LSB  = 16;
   localparam logic [DC_W-1:0] DATA_MIN_RST  = 13'h0200;
   localparam logic [DC_W-1:0] DATA_SPAN_RST = 13'h0c00;
   localparam logic [DC_W-1:0] DIAG_LO_RST   = 13'h00cd;
   localparam logic [DC_W-1:0] DIAG_HI_RST   = 13'h0f33;

   // pwm period in clock cycles
   localparam int unsigned PER_W            = 20;
   localparam int unsigned PWM_FREQ_RST_HZ  = 1000;
   localparam int unsigned PWM_PER_RST      = CLK_HZ / PWM_FREQ_RST_HZ;

   // unit time, counted in half units so x.5 windows stay exact
   localparam int unsigned UT_BASE_NS = 1500;
   localparam int unsigned UT_STEP_NS = 500;
   localparam logic [8:0] HALF_BASE_CYC = 9'(UT_BASE_NS * CLK_MHZ / 2000);
   localparam logic [8:0] HALF_STEP_CYC = 9'(UT_STEP_NS * CLK_MHZ / 2000);

   // frame lengths in unit times
   localparam logic [7:0] SYNC_UT     = 8'h38;
   localparam logic [7:0] NIB_BASE_UT = 8'h0c;
   localparam logic [7:0] END_UT      = 8'h0c;
   localparam logic [7:0] TRIG_CONST_UT = 8'h5a;
   localparam logic [7:0] TRIG_TAIL_UT  = 8'h0c;
   localparam logic [7:0] NLOW3_UT    = 8'h03;
   localparam logic [7:0] NLOW5_UT    = 8'h05;

   // trigger low windows per address, in half unit times
   localparam logic [7:0] WIN0_LO = 8'h12;
   localparam logic [7:0] WIN0_HI = 8'h18;
   localparam logic [7:0] WIN1_LO = 8'h26;
   localparam logic [7:0] WIN1_HI = 8'h2e;
   localparam logic [7:0] WIN2_LO = 8'h47;
   localparam logic [7:0] WIN2_HI = 8'h51;
   localparam logic [7:0] WIN3_LO = 8'h7b;
   localparam logic [7:0] WIN3_HI = 8'h87;

   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [3:0] CRC_POLY = 4'hd;

   // one nibble into the 4-bit checksum, msb first
   function automatic logic [3:0] aop_crc_nib(input logic [3:0] crc,
                                              input logic [3:0] nib);
      logic [3:0] c;
      logic       fb;
      c = crc;
      for (int i = 3; i >= 0; i--)
      begin
         fb = c[3] ^ nib[i];
         c  = {c[2:0], 1'b0};
         if (fb)
            c = c ^ CRC_POLY;
      end
      return c;
   endfunction

endpackage

// File: bench/aop_top_asserts.sv
// port assertions for the angle output block
`timescale 1ns/1ps
module aop_top_asserts
   import aop_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        line_out,
   input wire logic        line_oe
);
   logic [CTRL_W-1:0] ctl_ff;
   logic [15:0]       oe_len_ff;
   logic [15:0]       nlow;

   // pull-low length from the snooped control word, not from a design probe
   assign nlow = 16'((ctl_ff[CTRL_NLOW5] ? 10 : 6)
                 * (HALF_BASE_CYC + HALF_STEP_CYC * ctl_ff[6:5]));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_ff    <= CTRL_RST;
         oe_len_ff <= '0;
      end
      else
      begin
         if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
            ctl_ff <= pwdata[CTRL_W-1:0];
         oe_len_ff <= (line_oe && ctl_ff[CTRL_MODE]) ? oe_len_ff + 16'h1 : '0;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence

   apb_answer_a: assert property (setup_s |=> access_s)
      else $error("no access answer after setup");
   ready_place_a: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   bad_addr_a: assert property (setup_s ##0
      (paddr > OFS_STATUS || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped address not refused");
   good_addr_a: assert property (setup_s ##0
      (paddr <= OFS_STATUS && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped address refused");
   err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returns data");
   pwm_drive_a: assert property (!ctl_ff[CTRL_MODE] && $past(presetn)
      && !$past(ctl_ff[CTRL_MODE]) |-> line_oe)
      else $error("pwm output not driven");
   nib_release_a: assert property (ctl_ff[CTRL_MODE]
      && $past(ctl_ff[CTRL_MODE], 4) |-> !line_out)
      else $error("nibble mode drives high");
   nib_pulse_a: assert property (ctl_ff[CTRL_MODE] && $fell(line_oe)
      && oe_len_ff > 16'd8 |-> oe_len_ff + 16'd2 >= nlow
      && oe_len_ff <= nlow + 16'd2)
      else $error("nibble low time wrong");
endmodule

bind aop_top aop_top_asserts u_asserts (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_out, .line_oe);

// File: bench/aop_ecu.sv
// far-side controller model: wire pull-up, trigger pulses, edge log
`timescale 1ns/1ps
module aop_ecu
(
   input  wire logic pclk,
   input  wire logic line_out,
   input  wire logic line_oe,
   output logic      line_in
);
   logic pull;
   logic last;
   int   now;
   int   n_fall;
   int   fall_t[16];

   // a released wire rises through the pull-up, no stale level survives
   assign line_in = !pull && (line_oe ? line_out : 1'b1);

   initial
   begin
      pull   = 1'b0;
      last   = 1'b1;
      now    = 0;
      n_fall = 0;
   end

   // low time selects the addressed sensor; caller waits out the frame
   task automatic trigger(input int low_cyc);
      pull <= 1'b1;
      repeat (low_cyc) @(posedge pclk);
      pull <= 1'b0;
   endtask

   always @(posedge pclk)
   begin
      now = now + 1;
      if (last && !line_in && n_fall < 16)
      begin
         fall_t[n_fall] = now;
         n_fall = n_fall + 1;
      end
      last = line_in;
   end
endmodule

// File: bench/aop_top_tb.sv
// self-checking bench for the angle output block
`timescale 1ns/1ps
module aop_top_tb;
   import aop_pkg::*;
   localparam int PER = 1000;
   localparam int UT  = 150;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        fault_warn, selftest_fail, line_in, line_out, line_oe;
   logic        ssm_data, ssm_start;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] angle_code;
   int          n_fail, tests_run;

   aop_top #(.PWM_PER_DEF(PER)) uut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .angle_code,
      .fault_warn, .selftest_fail, .ssm_data, .ssm_start,
      .address_strap_a(1'b1), .address_strap_b(1'b0), .line_in,
      .line_out, .line_oe);
   aop_ecu ecu (.pclk, .line_out, .line_oe, .line_in);

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++k < 20);
      if (k == 20)
         check(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // counts cycles of one complete high stretch of the output
   task automatic high_run(output int n);
      int k;
      k = 0;
      while (line_out !== 1'b0 && k++ < 3 * PER) @(posedge pclk);
      while (line_out !== 1'b1 && k++ < 3 * PER) @(posedge pclk);
      for (n = 0; line_out === 1'b1 && n < 3 * PER; n++) @(posedge pclk);
   endtask

   // earlier stretches may still carry the previous setting
   task automatic pwm_chk(input int exp, input int runs);
      int n;
      repeat (runs) high_run(n);
      check(n, exp);
   endtask

   function automatic int duty(int per, int lo, int sp, int ang);
      return per * (lo + ang * sp / 4096) / 4096;
   endfunction

   function automatic logic [3:0] crc4(input logic [19:0] s);
      logic [3:0] c;
      c = 4'h5;
      for (int i = 19; i >= 0; i--)
         c = {c[2:0], 1'b0} ^ ((c[3] ^ s[i]) ? 4'hd : 4'h0);
      return c;
   endfunction

   task automatic t_regs();
      logic [31:0] rv[4];
      rv = '{32'h004, PER, 32'h0c000200, 32'h0f3300cd};
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[3:0], 4'h9);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check(rd, rv[i]);
      end
      apb(1'b0, 8'h14, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      repeat (PER) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[3], 1'b0);
   endtask

   task automatic t_diag();
      fault_warn <= 1'b1;
      @(posedge pclk);
      fault_warn <= 1'b0;
      pwm_chk(duty(PER, 205, 0, 0), 1);
      pwm_chk(duty(PER, 512, 3072, 0), 1);
      selftest_fail <= 1'b1;
      pwm_chk(duty(PER, 3891, 0, 0), 2);
      selftest_fail <= 1'b0;
   endtask

   task automatic t_pwm();
      int ang[3];
      ang = '{0, 2048, 4095};
      foreach (ang[i])
      begin
         angle_code <= 12'(ang[i]);
         pwm_chk(duty(PER, 512, 3072, ang[i]), 2);
      end
      apb(1'b1, OFS_DATA_DC, 32'h0800_0400);
      apb(1'b0, OFS_DATA_DC, 32'h0);
      check(rd, 32'h0800_0400);
      pwm_chk(duty(PER, 1024, 2048, 4095), 2);
      apb(1'b1, OFS_CTRL, 32'h006);
      pwm_chk(duty(PER, 1024, 2048, 4095), 2);
      apb(1'b1, OFS_PERIOD, 32'd800);
      pwm_chk(duty(800, 1024, 2048, 4095), 3);
   endtask

   task automatic t_nibble();
      int k;
      int eg[8];
      eg = '{33, 56, 17, 22, 17, 24, 12, 12 + crc4({4'h5, 12'ha5c, 4'h0})};
      k = 0;
      angle_code <= 12'ha5c;
      fault_warn <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h115);
      repeat (20) @(posedge pclk);
      ecu.n_fall = 0;
      ecu.trigger(3140);
      while (ecu.n_fall < 9 && k++ < 40000) @(posedge pclk);
      for (int i = 0; i < 8; i++)
         check((ecu.fall_t[i+1] - ecu.fall_t[i] + UT/2) / UT, eg[i]);
      repeat (14 * UT) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[11:2], {4'h5, 4'h1, 2'h0});
      ecu.n_fall = 0;
      ecu.trigger(1500);
      repeat (120 * UT) @(posedge pclk);
      check(ecu.n_fall, 1);
   endtask

   initial
   begin
      n_fail = 0;
      tests_run = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {angle_code, fault_warn, selftest_fail} = '0;
      {ssm_data, ssm_start} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_diag();
      t_pwm();
      t_nibble();
      give_verdict();
   end

   initial
   begin
      #1_500_000;
      n_fail++;
      give_verdict();
   end
endmodule
